//--- common/dfs_defs.svh
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH

// ==========================================================
// Register byte addresses
`define DFS_HS_CTL_ADDR 8'h00
`define DFS_LS_CTL_ADDR 8'h04
`define DFS_MODE_CTL_ADDR 8'h08
`define DFS_HS_STAT_ADDR 8'h0C
`define DFS_LS_STAT_ADDR 8'h10
`define DFS_WD_STAT_ADDR 8'h14
`define DFS_SRC_ADDR 8'h18
`define DFS_IRQ_EN_ADDR 8'h1C
`define DFS_IST_ADDR 8'h20
`define DFS_ICLR_ADDR 8'h24

// ==========================================================
// Field positions
`define DFS_HS_EN_BIT 0
`define DFS_HS_PWM_BIT 1
`define DFS_LSA_EN_BIT 0
`define DFS_LSA_PWM_BIT 1
`define DFS_LSB_EN_BIT 2
`define DFS_LSB_PWM_BIT 3
`define DFS_OVSD_BIT 0
`define DFS_CL_BIT 0
`define DFS_OL_BIT 1
`define DFS_OT_BIT 2
`define DFS_LSB_CL_BIT 2
`define DFS_LSB_OL_BIT 3
`define DFS_WD_ERR_BIT 2
`define DFS_IRQ_HS_BIT 0
`define DFS_IRQ_LS_BIT 1

// ==========================================================
// Reset values and codes
`define DFS_CTRL_RST 4'h0
`define DFS_IRQ_EN_RST 2'h0
`define DFS_CODE_NONE 4'h0
`define DFS_CODE_HS 4'h2
`define DFS_CODE_LS 4'h3
`define DFS_RESP_OKAY 2'h0
`define DFS_RESP_SLVERR 2'h2

`endif

//--- common/dfs_pkg.sv
// ==========================================================
// Types shared by the fault supervisor
package dfs_pkg;

    typedef enum logic [2:0] {
        DFS_MODE_RESET,
        DFS_MODE_NREQ,
        DFS_MODE_NORMAL,
        DFS_MODE_STOP,
        DFS_MODE_SLEEP
    } dfs_mode_type;

    // Whole register state of the top module
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] hs_ctl;
        logic [3:0] ls_ctl;
        logic ov_en;
        logic [1:0] irq_en;
        logic [1:0] pend;
        logic hs_sd;
        logic ls_sd;
        logic hs_therm;
        logic ls_therm;
        logic wd_err;
        logic hs_out;
        logic lsa_out;
        logic lsb_out;
        logic irq_act;
        logic sleep_req;
    } dfs_state_type;

endpackage

//--- core/dfs_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser, one chain per bit
module dfs_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // First stage feeds only the second stage
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    sync_r <= meta_r;
                end
            end
            assign q[i] = sync_r;
        end
    endgenerate
endmodule

`default_nettype wire

//--- core/dfs_top.sv
// Notes on behaviour
// - HS overtemp: off, all flags, code 0010
// - HS stays off until cleared plus write
// - HS thermal shows open-load and limit together
// - HS open-load flag follows low current in Normal and Request only
// - HS current limit keeps output, flag bit0
// - HS enable plus PWM select follows pin
// - HS enable bit switches output
// - Overvoltage with enable shuts HS off
// - HS overtemp latched; IRQ only if enabled
// - LS overtemp: both off, flags, code 0011
// - LS stays off until cleared plus write
// - LS limit keeps on, flags bit0/bit2
// - Floating config pin in Reset mode sets watchdog error
// - Reset mode undervoltage, supply fine: sleep
// - Interrupts only in Normal, Request, Stop
// - Masked fault: IRQ high, no source
// - LS enable plus PWM select follows pin, except in Stop and Sleep
// - LS overtemp IRQ only if enabled
`include "dfs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dfs_top
    import dfs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dfs_mode_type op_mode,
    input wire logic direct_pwm_input,
    input wire logic hs_overtemp_in,
    input wire logic ls_overtemp_in,
    input wire logic supply_overvoltage_in,
    input wire logic hs_open_load_in,
    input wire logic hs_current_limit_in,
    input wire logic ls_a_open_load_in,
    input wire logic ls_a_current_limit_in,
    input wire logic ls_b_open_load_in,
    input wire logic ls_b_current_limit_in,
    input wire logic watchdog_config_pin_floating,
    input wire logic regulator_undervoltage_in,
    input wire logic supply_undervoltage_flag,
    output logic high_side_out,
    output logic low_side_a_out,
    output logic low_side_b_out,
    output logic irq_n,
    output logic wd_internal_timebase,
    output logic sleep_request
);
    // ======================================================
    // Pin synchronisers
    logic [12:0] pin_s;
    logic pwm_s, hs_ot, ls_ot, ovp, hs_ol, hs_cl;
    logic lsa_ol, lsa_cl, lsb_ol, lsb_cl, wd_float, reg_uv, sup_uv;

    dfs_sync #(.W(13)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({direct_pwm_input, hs_overtemp_in, ls_overtemp_in,
            supply_overvoltage_in, hs_open_load_in,
            hs_current_limit_in, ls_a_open_load_in,
            ls_a_current_limit_in, ls_b_open_load_in,
            ls_b_current_limit_in, watchdog_config_pin_floating,
            regulator_undervoltage_in, supply_undervoltage_flag}),
        .q(pin_s)
    );

    assign {pwm_s, hs_ot, ls_ot, ovp, hs_ol, hs_cl, lsa_ol, lsa_cl,
            lsb_ol, lsb_cl, wd_float, reg_uv, sup_uv} = pin_s;

    // ======================================================
    // Address decode, shared by read and write paths
    function automatic logic [3:0] dfs_decode(input logic [7:0] a);
        case (a)
            `DFS_HS_CTL_ADDR: dfs_decode = 4'h1;
            `DFS_LS_CTL_ADDR: dfs_decode = 4'h2;
            `DFS_MODE_CTL_ADDR: dfs_decode = 4'h3;
            `DFS_HS_STAT_ADDR: dfs_decode = 4'h4;
            `DFS_LS_STAT_ADDR: dfs_decode = 4'h5;
            `DFS_WD_STAT_ADDR: dfs_decode = 4'h6;
            `DFS_SRC_ADDR: dfs_decode = 4'h7;
            `DFS_IRQ_EN_ADDR: dfs_decode = 4'h8;
            `DFS_IST_ADDR: dfs_decode = 4'h9;
            `DFS_ICLR_ADDR: dfs_decode = 4'hA;
            default: dfs_decode = 4'h0;
        endcase
    endfunction

    dfs_state_type s_r, s_nxt;

    // ======================================================
    // Combinational views of the state
    logic aw_take, w_take, ar_take, do_wr;
    logic [7:0] wa;
    logic [7:0] wd;
    logic wr_hs_ctl, wr_ls_ctl, irq_mode, ol_mode, drv_mode;
    logic hs_cause, ls_cause;
    logic [2:0] hs_stat;
    logic [3:0] ls_stat;
    logic [3:0] src_code;
    logic [1:0] set_pend, clr_pend;

    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
    assign s_axi_arready = !s_r.rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    // Write goes ahead once address and data are both held
    assign do_wr = (s_r.aw_got || aw_take) && (s_r.w_got || w_take);
    assign wa = s_r.aw_got ? s_r.awaddr : s_axi_awaddr;
    assign wd = s_r.w_got ? s_r.wdata : s_axi_wdata[7:0];
    assign wr_hs_ctl = do_wr && dfs_decode(wa) == 4'h1 &&
                       (s_r.w_got ? s_r.wstrb0 : s_axi_wstrb[0]);
    assign wr_ls_ctl = do_wr && dfs_decode(wa) == 4'h2 &&
                       (s_r.w_got ? s_r.wstrb0 : s_axi_wstrb[0]);

    // Mode gating of diagnostics and drivers
    assign irq_mode = op_mode == DFS_MODE_NORMAL ||
                      op_mode == DFS_MODE_NREQ ||
                      op_mode == DFS_MODE_STOP;
    assign ol_mode = op_mode == DFS_MODE_NORMAL ||
                     op_mode == DFS_MODE_NREQ;
    assign drv_mode = op_mode != DFS_MODE_STOP &&
                      op_mode != DFS_MODE_SLEEP;

    // Shutdown causes
    assign hs_cause = hs_ot || (ovp && s_r.ov_en);
    assign ls_cause = ls_ot || (ovp && s_r.ov_en);

    // Status words; thermal latch forces every flag high
    always_comb begin
        hs_stat = 3'h0;
        hs_stat[`DFS_CL_BIT] = hs_cl || s_r.hs_therm;
        hs_stat[`DFS_OL_BIT] = (hs_ol && ol_mode) || s_r.hs_therm;
        hs_stat[`DFS_OT_BIT] = s_r.hs_therm;
        ls_stat = 4'h0;
        ls_stat[`DFS_CL_BIT] = lsa_cl || s_r.ls_therm;
        ls_stat[`DFS_OL_BIT] = (lsa_ol && ol_mode) || s_r.ls_therm;
        ls_stat[`DFS_LSB_CL_BIT] = lsb_cl || s_r.ls_therm;
        ls_stat[`DFS_LSB_OL_BIT] = (lsb_ol && ol_mode) || s_r.ls_therm;
    end

    // High-side source outranks low-side in the code
    always_comb begin
        if (s_r.pend[`DFS_IRQ_HS_BIT]) begin
            src_code = `DFS_CODE_HS;
        end else if (s_r.pend[`DFS_IRQ_LS_BIT]) begin
            src_code = `DFS_CODE_LS;
        end else begin
            src_code = `DFS_CODE_NONE;
        end
    end

    // Sources set only when enabled, so masked faults leave no trace
    always_comb begin
        set_pend = 2'h0;
        set_pend[`DFS_IRQ_HS_BIT] = hs_ot && irq_mode &&
            s_r.irq_en[`DFS_IRQ_HS_BIT];
        set_pend[`DFS_IRQ_LS_BIT] = ls_ot && irq_mode &&
            s_r.irq_en[`DFS_IRQ_LS_BIT];
        clr_pend = 2'h0;
        if (do_wr && dfs_decode(wa) == 4'hA) begin
            clr_pend = wd[1:0];
        end
    end

    // ======================================================
    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        // Write channel
        if (aw_take) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (w_take) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata[7:0];
            s_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (do_wr) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = dfs_decode(wa) == 4'h0 ?
                          `DFS_RESP_SLVERR : `DFS_RESP_OKAY;
            if (s_r.w_got ? s_r.wstrb0 : s_axi_wstrb[0]) begin
                case (dfs_decode(wa))
                    4'h1: s_nxt.hs_ctl = wd[1:0];
                    4'h2: s_nxt.ls_ctl = wd[3:0];
                    4'h3: s_nxt.ov_en = wd[`DFS_OVSD_BIT];
                    4'h8: s_nxt.irq_en = wd[1:0];
                    default: ;
                endcase
            end
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // Read channel
        if (ar_take) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `DFS_RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            case (dfs_decode(s_axi_araddr))
                4'h1: s_nxt.rdata[1:0] = s_r.hs_ctl;
                4'h2: s_nxt.rdata[3:0] = s_r.ls_ctl;
                4'h3: s_nxt.rdata[0] = s_r.ov_en;
                4'h4: s_nxt.rdata[2:0] = hs_stat;
                4'h5: s_nxt.rdata[3:0] = ls_stat;
                4'h6: s_nxt.rdata[`DFS_WD_ERR_BIT] = s_r.wd_err;
                4'h7: s_nxt.rdata[3:0] = src_code;
                4'h8: s_nxt.rdata[1:0] = s_r.irq_en;
                4'h9: s_nxt.rdata[1:0] = s_r.pend;
                4'hA: ;
                default: s_nxt.rresp = `DFS_RESP_SLVERR;
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        // Shutdown latches: a live cause beats the re-enable write
        if (hs_cause) begin
            s_nxt.hs_sd = 1'b1;
        end else if (wr_hs_ctl) begin
            s_nxt.hs_sd = 1'b0;
        end
        if (hs_ot) begin
            s_nxt.hs_therm = 1'b1;
        end else if (wr_hs_ctl) begin
            s_nxt.hs_therm = 1'b0;
        end
        if (ls_cause) begin
            s_nxt.ls_sd = 1'b1;
        end else if (wr_ls_ctl) begin
            s_nxt.ls_sd = 1'b0;
        end
        if (ls_ot) begin
            s_nxt.ls_therm = 1'b1;
        end else if (wr_ls_ctl) begin
            s_nxt.ls_therm = 1'b0;
        end
        // Sticky sources; a new event wins over its clear
        s_nxt.pend = (s_r.pend & ~clr_pend) | set_pend;
        // Drivers; current limit never turns them off
        s_nxt.hs_out = s_r.hs_ctl[`DFS_HS_EN_BIT] && !s_nxt.hs_sd &&
            (!s_r.hs_ctl[`DFS_HS_PWM_BIT] || pwm_s);
        s_nxt.lsa_out = s_r.ls_ctl[`DFS_LSA_EN_BIT] && !s_nxt.ls_sd &&
            drv_mode &&
            (!s_r.ls_ctl[`DFS_LSA_PWM_BIT] || pwm_s);
        s_nxt.lsb_out = s_r.ls_ctl[`DFS_LSB_EN_BIT] && !s_nxt.ls_sd &&
            drv_mode &&
            (!s_r.ls_ctl[`DFS_LSB_PWM_BIT] || pwm_s);
        // Config pin is only judged while in Reset mode
        if (op_mode == DFS_MODE_RESET) begin
            s_nxt.wd_err = wd_float;
        end
        s_nxt.sleep_req = op_mode == DFS_MODE_RESET && reg_uv &&
                          !sup_uv;
        s_nxt.irq_act = |(s_nxt.pend & s_nxt.irq_en);
    end

    // ======================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign high_side_out = s_r.hs_out;
    assign low_side_a_out = s_r.lsa_out;
    assign low_side_b_out = s_r.lsb_out;
    assign irq_n = !s_r.irq_act;
    assign wd_internal_timebase = s_r.wd_err;
    assign sleep_request = s_r.sleep_req;

    // ======================================================
    // Checks
    property p_hs_ot_off;
        @(posedge aclk) disable iff (!aresetn)
        hs_ot |=> !high_side_out && hs_stat == 3'h7;
    endproperty
    a_hs_ot_off: assert property (p_hs_ot_off)
        else $error("HS overtemp did not shut down");

    property p_hs_code;
        @(posedge aclk) disable iff (!aresetn)
        s_r.pend[`DFS_IRQ_HS_BIT] |-> src_code == `DFS_CODE_HS &&
            (!irq_n == s_r.irq_en[`DFS_IRQ_HS_BIT] ||
             s_r.pend[`DFS_IRQ_LS_BIT]);
    endproperty
    a_hs_code: assert property (p_hs_code)
        else $error("HS source code or IRQ wrong");

    property p_hs_stay_off;
        @(posedge aclk) disable iff (!aresetn)
        s_r.hs_sd && !wr_hs_ctl |=> s_r.hs_sd && !high_side_out;
    endproperty
    a_hs_stay_off: assert property (p_hs_stay_off)
        else $error("HS came back without write");

    property p_pwm_follow;
        @(posedge aclk) disable iff (!aresetn)
        s_r.hs_ctl == 2'h3 && !s_r.hs_sd && !hs_cause
            |=> high_side_out == $past(pwm_s);
    endproperty
    a_pwm_follow: assert property (p_pwm_follow)
        else $error("HS not following PWM pin");

    property p_ovp_off;
        @(posedge aclk) disable iff (!aresetn)
        ovp && s_r.ov_en |=> !high_side_out && s_r.hs_sd;
    endproperty
    a_ovp_off: assert property (p_ovp_off)
        else $error("Overvoltage left HS on");

    property p_masked;
        @(posedge aclk) disable iff (!aresetn)
        !s_r.irq_en[`DFS_IRQ_HS_BIT] && !s_r.pend[`DFS_IRQ_HS_BIT] &&
            !wr_hs_ctl |=> !s_r.pend[`DFS_IRQ_HS_BIT];
    endproperty
    a_masked: assert property (p_masked)
        else $error("Masked source was set");

    property p_ls_ot_off;
        @(posedge aclk) disable iff (!aresetn)
        ls_ot |=> !low_side_a_out && !low_side_b_out && ls_stat == 4'hF;
    endproperty
    a_ls_ot_off: assert property (p_ls_ot_off)
        else $error("LS overtemp did not shut down");

    property p_no_irq_mode;
        @(posedge aclk) disable iff (!aresetn)
        !irq_mode && s_r.pend == 2'h0 |=> s_r.pend == 2'h0;
    endproperty
    a_no_irq_mode: assert property (p_no_irq_mode)
        else $error("Source set outside allowed modes");

    property p_sleep;
        @(posedge aclk) disable iff (!aresetn)
        op_mode == DFS_MODE_RESET && reg_uv && !sup_uv |=> sleep_request;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("No sleep request on undervoltage");

    property p_wd_err;
        @(posedge aclk) disable iff (!aresetn)
        op_mode == DFS_MODE_RESET && wd_float |=> wd_internal_timebase;
    endproperty
    a_wd_err: assert property (p_wd_err)
        else $error("Watchdog error not flagged");
endmodule

`default_nettype wire

//--- test/dfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host controller: register master on the block's bus
module dfs_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Bus idle from time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end

    // Control writes are the only way back on after a shutdown
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input int gap, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready)
                   || (s_axi_wvalid && !s_axi_wready));
        // Slow host: the response is accepted gap cycles late, at once when gap is 0
        repeat (gap) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- test/test_driver_fault_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defs.svh"

// ==========================================================
// Self-checking bench for the fault supervisor
module test_driver_fault_supervisor
    import dfs_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    dfs_mode_type op_mode = DFS_MODE_NORMAL;
    logic [12:0] pins = '0;
    logic direct_pwm_input, hs_overtemp_in, ls_overtemp_in;
    logic supply_overvoltage_in, hs_open_load_in, hs_current_limit_in;
    logic ls_a_open_load_in, ls_a_current_limit_in, ls_b_open_load_in;
    logic ls_b_current_limit_in, watchdog_config_pin_floating;
    logic regulator_undervoltage_in, supply_undervoltage_flag;
    logic high_side_out, low_side_a_out, low_side_b_out, irq_n;
    logic wd_internal_timebase, sleep_request;
    logic [31:0] seed = 32'h0000_25e8;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    localparam int PWM = 0, HOT = 1, LOT = 2, OV = 3, HOL = 4, HCL = 5;
    localparam int ACL = 7, BCL = 9, WDF = 10, RUV = 11, SUV = 12;
    localparam logic [7:0] HSC = `DFS_HS_CTL_ADDR, LSC = `DFS_LS_CTL_ADDR;
    localparam logic [7:0] HSS = `DFS_HS_STAT_ADDR, LSS = `DFS_LS_STAT_ADDR;
    localparam logic [7:0] ISA = `DFS_SRC_ADDR, IMA = `DFS_IRQ_EN_ADDR;
    localparam logic [7:0] ICL = `DFS_ICLR_ADDR;

    // Loose pins kept in one vector so tasks can index them
    assign {supply_undervoltage_flag, regulator_undervoltage_in,
            watchdog_config_pin_floating, ls_b_current_limit_in,
            ls_b_open_load_in, ls_a_current_limit_in, ls_a_open_load_in,
            hs_current_limit_in, hs_open_load_in, supply_overvoltage_in,
            ls_overtemp_in, hs_overtemp_in, direct_pwm_input} = pins;

    dfs_top i_dfs_top (.*);
    dfs_host_model i_dfs_host_model (.*);

    // ==========================================================
    // Clock and hang guard, far above the expected run length
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Thermal latch forces every flag of its status register
    function automatic logic [31:0] exp_hs(input logic ot, ol, cl);
        logic [31:0] v;
        v = '0;
        v[`DFS_OT_BIT] = ot;
        v[`DFS_OL_BIT] = ol | ot;
        v[`DFS_CL_BIT] = cl | ot;
        return v;
    endfunction
    function automatic logic [31:0] exp_ls(input logic ot, acl, bcl);
        return ot ? 32'hf : {29'h0, bcl, 1'b0, acl};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen,
                     want);
        end
    endtask

    // Pins pass two sync flops, then one more edge to the outputs
    task automatic settle();
        repeat (5) @(posedge aclk);
        #1;
    endtask
    task automatic pin(input int i, input logic v);
        @(posedge aclk);
        pins[i] <= v;
        settle();
    endtask
    task automatic md(input dfs_mode_type m);
        @(posedge aclk);
        op_mode <= m;
        settle();
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        seed = xs(seed);
        i_dfs_host_model.wr(a, d, int'(seed[1:0]), r);
        chk(r, `DFS_RESP_OKAY);
        settle();
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] d;
        logic [1:0] r;
        i_dfs_host_model.rd(a, d, r);
        chk(d, want);
        chk(r, `DFS_RESP_OKAY);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        dfs_mode_type mds[4];
        logic [3:0] fire;
        mds = '{DFS_MODE_RESET, DFS_MODE_SLEEP, DFS_MODE_STOP,
                DFS_MODE_NREQ};
        fire = 4'b1100;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk(irq_n, 1'b1);
        rchk(ISA, `DFS_CODE_NONE);
        // Unmapped place: error answer, no data
        i_dfs_host_model.rd(8'h40, d, r);
        chk(d, 32'h0);
        chk(r, `DFS_RESP_SLVERR);
        i_dfs_host_model.wr(8'h40, 32'hff, 0, r);
        chk(r, `DFS_RESP_SLVERR);
        w(HSC, 32'h1);
        chk(high_side_out, 1'b1);
        $display("test bus and enable done");
        // Direct drive follows the pin only with select set
        w(HSC, 32'h3);
        w(LSC, 32'hf);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            pin(PWM, seed[0]);
            chk(high_side_out, seed[0]);
            chk({low_side_a_out, low_side_b_out}, {2{seed[0]}});
        end
        w(HSC, 32'h1);
        w(LSC, 32'h5);
        pin(PWM, 1'b0);
        chk(high_side_out, 1'b1);
        $display("test direct drive done");
        // Current limit keeps outputs on, flags follow
        pin(ACL, 1'b1);
        pin(BCL, 1'b1);
        pin(HCL, 1'b1);
        chk({low_side_a_out, low_side_b_out}, 2'b11);
        rchk(LSS, exp_ls(0, 1, 1));
        chk(high_side_out, 1'b1);
        rchk(HSS, exp_hs(0, 0, 1));
        pin(ACL, 1'b0);
        rchk(LSS, exp_ls(0, 0, 1));
        {pins[BCL], pins[HCL]} <= 2'b00;
        pin(HOL, 1'b1);
        rchk(HSS, exp_hs(0, 1, 0));
        md(DFS_MODE_STOP);
        rchk(HSS, exp_hs(0, 0, 0));
        md(DFS_MODE_NORMAL);
        pin(HOL, 1'b0);
        rchk(HSS, exp_hs(0, 0, 0));
        // Masked overtemperature: shutdown, no source, no irq
        pin(HOT, 1'b1);
        chk(high_side_out, 1'b0);
        chk(irq_n, 1'b1);
        rchk(ISA, `DFS_CODE_NONE);
        pin(HOT, 1'b0);
        w(HSC, 32'h1);
        w(IMA, 32'h3);
        pin(HOT, 1'b1);
        chk(irq_n, 1'b0);
        rchk(HSS, exp_hs(1, 0, 0));
        rchk(ISA, `DFS_CODE_HS);
        w(HSC, 32'h1);
        chk(high_side_out, 1'b0);
        pin(HOT, 1'b0);
        chk(high_side_out, 1'b0);
        chk(irq_n, 1'b0);
        w(HSC, 32'h1);
        chk(high_side_out, 1'b1);
        w(ICL, 32'h3);
        chk(irq_n, 1'b1);
        pin(LOT, 1'b1);
        chk({low_side_a_out, low_side_b_out}, 2'b00);
        chk(irq_n, 1'b0);
        rchk(LSS, exp_ls(1, 0, 0));
        rchk(ISA, `DFS_CODE_LS);
        pin(LOT, 1'b0);
        chk(low_side_a_out, 1'b0);
        w(LSC, 32'h5);
        chk({low_side_a_out, low_side_b_out}, 2'b11);
        w(ICL, 32'h3);
        w(IMA, 32'h1);
        pin(LOT, 1'b1);
        chk(irq_n, 1'b1);
        pin(LOT, 1'b0);
        $display("test thermal done");
        // Overvoltage shutdown, back on only by a control write
        w(`DFS_MODE_CTL_ADDR, 32'h1);
        pin(OV, 1'b1);
        chk(high_side_out, 1'b0);
        pin(OV, 1'b0);
        chk(high_side_out, 1'b0);
        w(HSC, 32'h1);
        chk(high_side_out, 1'b1);
        // Interrupts only in the modes that allow them
        w(IMA, 32'h3);
        foreach (mds[i]) begin
            md(mds[i]);
            pin(HOT, 1'b1);
            chk(irq_n, !fire[i]);
            pin(HOT, 1'b0);
            w(ICL, 32'h3);
        end
        md(DFS_MODE_RESET);
        pin(WDF, 1'b1);
        chk(wd_internal_timebase, 1'b1);
        rchk(`DFS_WD_STAT_ADDR, 32'h1 << `DFS_WD_ERR_BIT);
        pin(RUV, 1'b1);
        chk(sleep_request, 1'b1);
        pin(SUV, 1'b1);
        chk(sleep_request, 1'b0);
        $display("test modes done");
        report_and_stop();
    end
endmodule

`default_nettype wire
